// [rtl/cta8_core.sv]
// Contract
// - sixteen byte registers, eight pairs, set select at status bit 5.
// - set select picks bytes 0-3 or 4-7 as X,A,C,B; 8-15 fixed pointers.
// - set select picks pairs 0,1 or 2,3 as word accumulator and counter.
// - short direct spans FE20H-FF1FH; word short direct uses even address.
// - relative target is next instruction plus signed byte, -128..+127.
// - call operand reaches 800H-FFFH; table operand even 40H-7EH.
// - shift, rotate, repeat count is a 3-bit immediate 0..7.
// - pair 5 only in system push/pop, status word only in user push/pop.
// - absolute span 0000H-FDFFH; byte moves to FFFFH; table shift FE00H-FEFFH.
// - indirect, based indexed, based with byte, indexed with word base.
// - auto-modify forms step pointer by one after the access.
// - one pair named in both pair classes gets distinct codes.
// - byte move/exchange keep flags; low status load replaces the whole low status byte.
// - word move and exchange never touch flags.
// - immediate move to standby or watchdog register has another length.
// - add/subtract write result and carry; carry variants use carry in.
// - arithmetic sets sign, zero, aux carry, carry, and overflow.
// - logic ops set sign, zero, parity; aux carry and carry kept.
// - compare subtracts, sets flags, writes nothing.
// - short direct address bit 8 is set for offsets 00H-1FH.
// - special registers FF00H-FF1FH reachable by both modes.
module cta8_core #(
    parameter logic [7:0] STANDBY_OFF  = 8'hC0,
    parameter logic [7:0] WATCHDOG_OFF = 8'hC1
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    input  wire cta8_pkg::cta8_cmd_s  cmd,
    output logic                      done,
    output cta8_pkg::cta8_mem_s       mem_req,
    input  wire logic [15:0]          mem_rdata,
    input  wire cta8_pkg::cta8_opnd_s opnd,
    output cta8_pkg::cta8_dec_s       dec,
    input  wire logic [7:0]           rb_addr,
    input  wire logic [7:0]           rb_wdata,
    input  wire logic                 rb_wr,
    input  wire logic                 rb_rd,
    output logic [7:0]                rb_rdata
);
    typedef enum logic [1:0] {S_IDLE, S_REQ, S_EXEC} cta8_state_e;

    // ==========================================================
    // state
    // ==========================================================
    cta8_state_e         state_reg, state_next;
    logic [7:0]          gpr_reg [16];
    logic [7:0]          gpr_next [16];
    logic [7:0]          status_low_byte_reg, status_low_byte_next, status_high_byte_reg, status_high_byte_next;
    cta8_pkg::cta8_cmd_s cmd_reg, cmd_next;
    logic [15:0]         ea_reg, ea_next;
    cta8_pkg::cta8_mem_s mem_reg, mem_next;
    logic                done_reg, done_next;
    logic                odd_reg, odd_next;
    logic [7:0]          rd_reg, rd_next;
    cta8_pkg::cta8_dec_s dec_reg, dec_next;

    // ==========================================================
    // register roles
    // ==========================================================
    logic       register_set_select;
    logic [3:0] acc_idx, b_idx;
    logic [2:0] wacc;
    assign register_set_select = status_low_byte_reg[cta8_pkg::FLG_RSS];
    assign acc_idx = register_set_select ? cta8_pkg::R_A1 : cta8_pkg::R_A0;
    assign b_idx   = register_set_select ? cta8_pkg::R_B1 : cta8_pkg::R_B0;
    assign wacc    = register_set_select ? cta8_pkg::PAIR_ACC1 : cta8_pkg::PAIR_ACC0;

    function automatic logic [15:0] pair_val(input logic [7:0] g [16], input logic [2:0] p);
        pair_val = {g[{p, 1'b1}], g[{p, 1'b0}]};
    endfunction

    // ==========================================================
    // effective address
    // ==========================================================
    logic [15:0] ea_new, idx_val, ptr_val;
    always_comb begin
        ptr_val = pair_val(gpr_reg, cmd.ptr);
        case (cmd.idx)
            2'h0:    idx_val = {8'h00, gpr_reg[acc_idx]};
            2'h1:    idx_val = {8'h00, gpr_reg[b_idx]};
            2'h2:    idx_val = pair_val(gpr_reg, cta8_pkg::PAIR_DE);
            default: idx_val = pair_val(gpr_reg, cta8_pkg::PAIR_HL);
        endcase
        case (cmd.am)
            cta8_pkg::AM_SADDR:   ea_new = {cta8_pkg::SHORT_TOP, cmd.imm[7:0] < cta8_pkg::SADDR_SPL, cmd.imm[7:0]};
            cta8_pkg::AM_SFR:     ea_new = {cta8_pkg::SFR_PAGE, cmd.imm[7:0]};
            cta8_pkg::AM_ABS:     ea_new = cmd.imm;
            cta8_pkg::AM_IND:     ea_new = ptr_val;
            cta8_pkg::AM_BIDX:    ea_new = ptr_val + idx_val;
            cta8_pkg::AM_BASED:   ea_new = ptr_val + {8'h00, cmd.imm[7:0]};
            cta8_pkg::AM_INDEXED: ea_new = cmd.imm + idx_val;
            default:              ea_new = 16'h0000;
        endcase
    end

    logic is_word_new, needs_mem;
    assign is_word_new = (cmd.op == cta8_pkg::OP_MOVW) || (cmd.op == cta8_pkg::OP_XCHW);
    assign needs_mem   = cmd.am inside {cta8_pkg::AM_SADDR, cta8_pkg::AM_SFR, cta8_pkg::AM_ABS,
                                        cta8_pkg::AM_IND, cta8_pkg::AM_BIDX, cta8_pkg::AM_BASED,
                                        cta8_pkg::AM_INDEXED};

    // ==========================================================
    // byte alu
    // ==========================================================
    logic        is_mem_r, is_word_r, is_sub, use_cy;
    logic [3:0]  dreg;
    logic [7:0]  opa, opb, opb2, res8, fl_new;
    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic        cin_eff, cy_o, ac_o, ov_o;
    always_comb begin
        is_mem_r  = cmd_reg.am inside {cta8_pkg::AM_SADDR, cta8_pkg::AM_SFR, cta8_pkg::AM_ABS,
                                       cta8_pkg::AM_IND, cta8_pkg::AM_BIDX, cta8_pkg::AM_BASED,
                                       cta8_pkg::AM_INDEXED};
        is_word_r = (cmd_reg.op == cta8_pkg::OP_MOVW) || (cmd_reg.op == cta8_pkg::OP_XCHW);
        dreg      = cmd_reg.dst_acc ? acc_idx : cmd_reg.dst;
        opa       = cmd_reg.mem_dst ? mem_rdata[7:0] : gpr_reg[dreg];
        if (cmd_reg.mem_dst) begin
            opb = gpr_reg[acc_idx];
        end else if (is_mem_r) begin
            opb = mem_rdata[7:0];
        end else if (cmd_reg.am == cta8_pkg::AM_IMM) begin
            opb = cmd_reg.imm[7:0];
        end else begin
            opb = gpr_reg[cmd_reg.src];
        end
        is_sub  = cmd_reg.op inside {cta8_pkg::OP_SUB, cta8_pkg::OP_SUBTRACT_WITH_BORROW, cta8_pkg::OP_CMP};
        use_cy  = cmd_reg.op inside {cta8_pkg::OP_ADD_WITH_CARRY, cta8_pkg::OP_SUBTRACT_WITH_BORROW};
        cin_eff = is_sub ? ~(use_cy & status_low_byte_reg[cta8_pkg::FLG_CY]) : (use_cy & status_low_byte_reg[cta8_pkg::FLG_CY]);
        opb2    = is_sub ? ~opb : opb;
        sum9    = {1'b0, opa} + {1'b0, opb2} + {8'h00, cin_eff};
        sum5    = {1'b0, opa[3:0]} + {1'b0, opb2[3:0]} + {4'h0, cin_eff};
        // carry is inverted adder carry on subtract
        cy_o    = is_sub ? ~sum9[8] : sum9[8];
        ac_o    = is_sub ? ~sum5[4] : sum5[4];
        ov_o    = (opa[7] == opb2[7]) && (sum9[7] != opa[7]);
        fl_new  = status_low_byte_reg;
        case (cmd_reg.op)
            cta8_pkg::OP_AND: res8 = opa & opb;
            cta8_pkg::OP_OR:  res8 = opa | opb;
            cta8_pkg::OP_XOR: res8 = opa ^ opb;
            default:          res8 = sum9[7:0];
        endcase
        if (cmd_reg.op inside {cta8_pkg::OP_AND, cta8_pkg::OP_OR, cta8_pkg::OP_XOR}) begin
            fl_new[cta8_pkg::FLG_S]  = res8[7];
            fl_new[cta8_pkg::FLG_Z]  = (res8 == 8'h00);
            fl_new[cta8_pkg::FLG_PV] = ~^res8;
        end else begin
            fl_new[cta8_pkg::FLG_S]  = res8[7];
            fl_new[cta8_pkg::FLG_Z]  = (res8 == 8'h00);
            fl_new[cta8_pkg::FLG_AC] = ac_o;
            fl_new[cta8_pkg::FLG_PV] = ov_o;
            fl_new[cta8_pkg::FLG_CY] = cy_o;
        end
    end

    // ==========================================================
    // sequencer and register file
    // ==========================================================
    logic [15:0] wsrc, wdst, pstep;
    logic [2:0]  wdp;
    always_comb begin
        state_next = state_reg;
        cmd_next   = cmd_reg;
        ea_next    = ea_reg;
        status_low_byte_next  = status_low_byte_reg;
        status_high_byte_next  = status_high_byte_reg;
        odd_next   = odd_reg;
        done_next  = 1'b0;
        mem_next   = '0;
        rd_next    = rd_reg;
        gpr_next   = gpr_reg;
        wdp        = cmd_reg.dst_acc ? wacc : cmd_reg.dst[2:0];
        wdst       = pair_val(gpr_reg, wdp);
        if (is_mem_r) begin
            wsrc = mem_rdata;
        end else if (cmd_reg.am == cta8_pkg::AM_IMM) begin
            wsrc = cmd_reg.imm;
        end else begin
            wsrc = pair_val(gpr_reg, cmd_reg.src[2:0]);
        end
        pstep = (cmd_reg.step == cta8_pkg::STEP_DEC) ? 16'hFFFF : 16'h0001;
        // bus writes land first; an executing op overrides the same byte
        if (rb_wr) begin
            if (rb_addr < cta8_pkg::RB_STATUS_LOW_BYTE) begin
                gpr_next[rb_addr[3:0]] = rb_wdata;
            end else if (rb_addr == cta8_pkg::RB_STATUS_LOW_BYTE) begin
                status_low_byte_next = rb_wdata;
            end else if (rb_addr == cta8_pkg::RB_STATUS_HIGH_BYTE) begin
                status_high_byte_next = rb_wdata;
            end else if (rb_addr == cta8_pkg::RB_STAT) begin
                odd_next = odd_reg & ~rb_wdata[1];
            end
        end
        if (rb_rd) begin
            if (rb_addr < cta8_pkg::RB_STATUS_LOW_BYTE) begin
                rd_next = gpr_reg[rb_addr[3:0]];
            end else if (rb_addr == cta8_pkg::RB_STATUS_LOW_BYTE) begin
                rd_next = status_low_byte_reg;
            end else if (rb_addr == cta8_pkg::RB_STATUS_HIGH_BYTE) begin
                rd_next = status_high_byte_reg;
            end else if (rb_addr == cta8_pkg::RB_STAT) begin
                rd_next = {6'h00, odd_reg, state_reg != S_IDLE};
            end else begin
                rd_next = 8'h00;
            end
        end
        case (state_reg)
            S_IDLE: begin
                if (cmd_valid) begin
                    cmd_next = cmd;
                    ea_next  = ea_new;
                    if (needs_mem) begin
                        mem_next.addr = is_word_new ? {ea_new[15:1], 1'b0} : ea_new;
                        mem_next.rd   = 1'b1;
                        mem_next.word = is_word_new;
                        state_next    = S_REQ;
                        // odd word request is latched, set wins over clear
                        if (is_word_new && ea_new[0]) begin
                            odd_next = 1'b1;
                        end
                    end else begin
                        state_next = S_EXEC;
                    end
                end
            end
            S_REQ: state_next = S_EXEC;
            S_EXEC: begin
                state_next    = S_IDLE;
                done_next     = 1'b1;
                mem_next.addr = is_word_r ? {ea_reg[15:1], 1'b0} : ea_reg;
                mem_next.word = is_word_r;
                case (cmd_reg.op)
                    cta8_pkg::OP_MOV: begin
                        if (cmd_reg.mem_dst) begin
                            mem_next.wr    = 1'b1;
                            mem_next.wdata = {8'h00, gpr_reg[acc_idx]};
                        end else begin
                            gpr_next[dreg] = opb;
                        end
                    end
                    cta8_pkg::OP_XCH: begin
                        if (is_mem_r) begin
                            mem_next.wr    = 1'b1;
                            mem_next.wdata = {8'h00, gpr_reg[dreg]};
                            gpr_next[dreg] = mem_rdata[7:0];
                        end else begin
                            gpr_next[dreg]        = gpr_reg[cmd_reg.src];
                            gpr_next[cmd_reg.src] = gpr_reg[dreg];
                        end
                    end
                    cta8_pkg::OP_MOVW: begin
                        if (cmd_reg.mem_dst) begin
                            mem_next.wr    = 1'b1;
                            mem_next.wdata = pair_val(gpr_reg, wacc);
                        end else begin
                            {gpr_next[{wdp, 1'b1}], gpr_next[{wdp, 1'b0}]} = wsrc;
                        end
                    end
                    cta8_pkg::OP_XCHW: begin
                        {gpr_next[{wdp, 1'b1}], gpr_next[{wdp, 1'b0}]} = wsrc;
                        if (is_mem_r) begin
                            mem_next.wr    = 1'b1;
                            mem_next.wdata = wdst;
                        end else begin
                            {gpr_next[{cmd_reg.src[2:0], 1'b1}], gpr_next[{cmd_reg.src[2:0], 1'b0}]} = wdst;
                        end
                    end
                    cta8_pkg::OP_LDSL: status_low_byte_next = opb;
                    cta8_pkg::OP_LDSH: status_high_byte_next = opb;
                    cta8_pkg::OP_RDSL: gpr_next[acc_idx] = status_low_byte_reg;
                    cta8_pkg::OP_RDSH: gpr_next[acc_idx] = status_high_byte_reg;
                    default: begin
                        status_low_byte_next = (status_low_byte_reg & ~cta8_pkg::ARITH_MASK) | (fl_new & cta8_pkg::ARITH_MASK);
                        if (cmd_reg.op != cta8_pkg::OP_CMP) begin
                            if (cmd_reg.mem_dst) begin
                                mem_next.wr    = 1'b1;
                                mem_next.wdata = {8'h00, res8};
                            end else begin
                                gpr_next[dreg] = res8;
                            end
                        end
                    end
                endcase
                if (cmd_reg.am == cta8_pkg::AM_IND && cmd_reg.step != cta8_pkg::STEP_NONE) begin
                    {gpr_next[{cmd_reg.ptr, 1'b1}], gpr_next[{cmd_reg.ptr, 1'b0}]} =
                        pair_val(gpr_reg, cmd_reg.ptr) + pstep;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    // ==========================================================
    // operand decode helpers
    // ==========================================================
    logic sp_sfr;
    always_comb begin
        dec_next.rel_target  = opnd.next_pc + {{8{opnd.disp[7]}}, opnd.disp};
        // call window and even table entries
        dec_next.call_target = {4'h0, cta8_pkg::CALL_BASE | {1'b0, opnd.call11}};
        dec_next.table_addr  = cta8_pkg::VEC_BASE | {2'h0, opnd.tbl5, 1'b0};
        dec_next.count       = opnd.cnt;
        // pair 5 system only, status word user only
        dec_next.post_ok     = opnd.post_psw ? ~opnd.post_sys
                             : (opnd.post_pair != cta8_pkg::PAIR_SYS) | opnd.post_sys;
        case (opnd.abs_kind)
            cta8_pkg::ABS_MOVB: dec_next.abs_ok = 1'b1;
            cta8_pkg::ABS_TBL:  dec_next.abs_ok = (opnd.abs_addr >= cta8_pkg::TBL_LO) &&
                                                  (opnd.abs_addr <= cta8_pkg::TBL_HI);
            default:            dec_next.abs_ok = (opnd.abs_addr <= cta8_pkg::ABS_MAX);
        endcase
        // standby and watchdog get the longer form
        sp_sfr           = (opnd.sfr_off == STANDBY_OFF) || (opnd.sfr_off == WATCHDOG_OFF);
        dec_next.sfr_len = sp_sfr ? cta8_pkg::LEN_SFR_SP : cta8_pkg::LEN_SFR;
        dec_next.code_rp  = cta8_pkg::CLS_RP | {1'b0, opnd.pair};
        dec_next.code_rp1 = cta8_pkg::CLS_RP1 | {1'b0, opnd.pair};
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
            for (int i = 0; i < 16; i++) begin
                gpr_reg[i] <= 8'h00;
            end
            status_low_byte_reg <= cta8_pkg::STATUS_LOW_BYTE_RST;
            status_high_byte_reg <= cta8_pkg::STATUS_HIGH_BYTE_RST;
            cmd_reg  <= '0;
            ea_reg   <= 16'h0000;
            mem_reg  <= '0;
            done_reg <= 1'b0;
            odd_reg  <= 1'b0;
            rd_reg   <= 8'h00;
            dec_reg  <= '0;
        end else if (ce) begin
            state_reg <= state_next;
            gpr_reg   <= gpr_next;
            status_low_byte_reg  <= status_low_byte_next;
            status_high_byte_reg  <= status_high_byte_next;
            cmd_reg   <= cmd_next;
            ea_reg    <= ea_next;
            mem_reg   <= mem_next;
            done_reg  <= done_next;
            odd_reg   <= odd_next;
            rd_reg    <= rd_next;
            dec_reg   <= dec_next;
        end
    end

    assign cmd_ready = (state_reg == S_IDLE) && ce;
    assign done      = done_reg;
    assign mem_req   = mem_reg;
    assign rb_rdata  = rd_reg;
    assign dec       = dec_reg;
endmodule

// [rtl/cta8_pkg.sv]
package cta8_pkg;
    // ==========================================================
    // opcodes, operand modes
    // ==========================================================
    typedef enum logic [3:0] {
        OP_MOV, OP_XCH, OP_MOVW, OP_XCHW, OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW,
        OP_AND, OP_OR, OP_XOR, OP_CMP, OP_LDSL, OP_LDSH, OP_RDSL, OP_RDSH
    } cta8_op_e;
    typedef enum logic [3:0] {
        AM_REG, AM_IMM, AM_SADDR, AM_SFR, AM_ABS, AM_IND, AM_BIDX, AM_BASED, AM_INDEXED
    } cta8_am_e;
    localparam logic [1:0] STEP_NONE = 2'h0;
    localparam logic [1:0] STEP_INC  = 2'h1;
    localparam logic [1:0] STEP_DEC  = 2'h2;
    // ==========================================================
    // flags and pair roles
    // ==========================================================
    localparam int FLG_CY  = 0;
    localparam int FLG_PV  = 2;
    localparam int FLG_AC  = 4;
    localparam int FLG_RSS = 5;
    localparam int FLG_Z   = 6;
    localparam int FLG_S   = 7;
    localparam logic [7:0] ARITH_MASK = 8'hD5;
    localparam logic [7:0] STATUS_LOW_BYTE_RST   = 8'h00;
    localparam logic [7:0] STATUS_HIGH_BYTE_RST   = 8'h00;
    localparam logic [2:0] PAIR_ACC0  = 3'h0;
    localparam logic [2:0] PAIR_ACC1  = 3'h2;
    localparam logic [2:0] PAIR_SYS   = 3'h5;
    localparam logic [2:0] PAIR_DE    = 3'h6;
    localparam logic [2:0] PAIR_HL    = 3'h7;
    localparam logic [3:0] R_A0 = 4'h1;
    localparam logic [3:0] R_B0 = 4'h3;
    localparam logic [3:0] R_A1 = 4'h5;
    localparam logic [3:0] R_B1 = 4'h7;
    // ==========================================================
    // address map
    // ==========================================================
    localparam logic [6:0]  SHORT_TOP  = 7'h7F;
    localparam logic [7:0]  SADDR_SPL  = 8'h20;
    localparam logic [7:0]  SFR_PAGE   = 8'hFF;
    localparam logic [15:0] ABS_MAX    = 16'hFDFF;
    localparam logic [15:0] TBL_LO     = 16'hFE00;
    localparam logic [15:0] TBL_HI     = 16'hFEFF;
    localparam logic [11:0] CALL_BASE  = 12'h800;
    localparam logic [7:0]  VEC_BASE   = 8'h40;
    localparam logic [2:0]  LEN_SFR    = 3'h3;
    localparam logic [2:0]  LEN_SFR_SP = 3'h4;
    localparam logic [3:0]  CLS_RP     = 4'h0;
    localparam logic [3:0]  CLS_RP1    = 4'h8;
    // register port
    localparam logic [7:0] RB_GPR  = 8'h00;
    localparam logic [7:0] RB_STATUS_LOW_BYTE = 8'h10;
    localparam logic [7:0] RB_STATUS_HIGH_BYTE = 8'h11;
    localparam logic [7:0] RB_STAT = 8'h12;
    // abs operand kinds
    localparam logic [1:0] ABS_NORM = 2'h0;
    localparam logic [1:0] ABS_MOVB = 2'h1;
    localparam logic [1:0] ABS_TBL  = 2'h2;
    // ==========================================================
    // carriers
    // ==========================================================
    typedef struct packed {
        cta8_op_e   op;
        cta8_am_e   am;
        logic       mem_dst;
        logic       dst_acc;
        logic [3:0] dst;
        logic [3:0] src;
        logic [2:0] ptr;
        logic [1:0] idx;
        logic [1:0] step;
        logic [15:0] imm;
    } cta8_cmd_s;
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cta8_mem_s;
    typedef struct packed {
        logic [15:0] next_pc;
        logic [7:0]  disp;
        logic [10:0] call11;
        logic [4:0]  tbl5;
        logic [2:0]  cnt;
        logic [2:0]  post_pair;
        logic        post_psw;
        logic        post_sys;
        logic [1:0]  abs_kind;
        logic [15:0] abs_addr;
        logic [7:0]  sfr_off;
        logic [2:0]  pair;
    } cta8_opnd_s;
    typedef struct packed {
        logic [15:0] rel_target;
        logic [15:0] call_target;
        logic [7:0]  table_addr;
        logic [2:0]  count;
        logic        post_ok;
        logic        abs_ok;
        logic [2:0]  sfr_len;
        logic [3:0]  code_rp;
        logic [3:0]  code_rp1;
    } cta8_dec_s;
endpackage

// [testbench/cpu_transfer_alu_8bit_test.sv]
module cpu_transfer_alu_8bit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk = 1'h0, rst_n = 1'h0, cmd_valid = 1'h0, rb_wr = 1'h0, rb_rd = 1'h0, done, cmd_ready;
    logic [7:0]           rb_addr = 8'h00, rb_wdata = 8'h00, rb_rdata, a, b, f, ra, got;
    logic [15:0]          mem_rdata = 16'h0000, exp, maddr;
    logic                 ce = 1'h1;
    cta8_pkg::cta8_mem_s  mreq;
    cta8_pkg::cta8_cmd_s  cmd = '0;
    cta8_pkg::cta8_opnd_s opnd = '0;
    int                   n_fail = 0, samples_checked = 0;
    cta8_core cta8_core_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .done(done), .mem_req(mreq), .mem_rdata(mem_rdata), .opnd(opnd), .dec(), .rb_addr(rb_addr),
        .rb_wdata(rb_wdata), .rb_wr(rb_wr), .rb_rd(rb_rd), .rb_rdata(rb_rdata));
    always #4 clk = ~clk;
    // read request address, taken mid-cycle while the pulse stands
    always @(negedge clk) if (mreq.rd) maddr = mreq.addr;
    always @(posedge clk) begin
        opnd      <= 77'({$urandom, $urandom, $urandom});
        mem_rdata <= 16'($urandom);
    end
    task automatic check8(string what, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    // one strobe per call, an idle edge after it so strobes never toggle twice in a step
    task automatic bus(logic w, logic [7:0] ad, logic [7:0] d);
        rb_addr  <= ad;
        rb_wdata <= d;
        rb_wr    <= w;
        rb_rd    <= !w;
        @(posedge clk);
        {rb_wr, rb_rd} <= 2'h0;
        @(negedge clk);
        got = rb_rdata;
        @(posedge clk);
    endtask
    task automatic run(cta8_pkg::cta8_op_e o, cta8_pkg::cta8_am_e m, logic [15:0] v);
        cmd       <= '{o, m, 1'h0, 1'h1, cta8_pkg::R_A0, 4'h0, 3'h7, 2'h0, 2'h0, v};
        cmd_valid <= 1'h1;
        @(posedge clk);
        cmd_valid <= 1'h0;
        repeat (4) if (done !== 1'h1) @(negedge clk);
        check8("done", 8'h01, {7'h00, done});
        @(posedge clk);
    endtask
    function automatic logic [15:0] model(logic [3:0] o, logic [7:0] a, b, f);
        logic [8:0] r;
        logic       s, c;
        s = o > 4'h5;
        c = f[0] & o[0] & !o[3];
        r = s ? {1'h0, a} - b - c : a + b + c;
        if (o == 4'h0) return {b, f};
        if (o[3] && o != 4'hB) begin
            r = o[1] ? a ^ b : o[0] ? a | b : a & b;
            return {r[7:0], r[7], !r[7:0], f[5:3], ~^r[7:0], f[1:0]};
        end
        return {o[3] ? a : r[7:0], r[7], !r[7:0], f[5], (s ? {1'h0, a[3:0]} < b[3:0] + c
            : a[3:0] + b[3:0] + c > 5'h0F), f[3], (a[7] ^ b[7] ^ !s) & (r[7] ^ a[7]), f[1], r[8]};
    endfunction
    task automatic end_sim();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(23069));
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        // first pass is the signed-overflow corner, later passes are random
        for (int i = 0; i < 48; i++) begin
            if ((i % 12) inside {[1:3]}) continue;
            a   = (i < 12) ? 8'h7F : 8'($urandom);
            b   = (i < 12) ? 8'h01 : 8'($urandom);
            f   = 8'($urandom) & 8'hF5;
            ra  = {4'h0, (f[5] ? cta8_pkg::R_A1 : cta8_pkg::R_A0)};
            exp = model(4'(i % 12), a, b, f);
            bus(1'h1, ra, a);
            bus(1'h1, cta8_pkg::RB_STATUS_LOW_BYTE, f);
            run(cta8_pkg::cta8_op_e'(4'(i % 12)), cta8_pkg::AM_IMM, {8'h00, b});
            bus(1'h0, ra, 8'h00);
            check8("acc", exp[15:8], got);
            bus(1'h0, cta8_pkg::RB_STATUS_LOW_BYTE, 8'h00);
            check8("flags", exp[7:0], got);
        end
        bus(1'h1, cta8_pkg::RB_STAT, 8'h02);
        run(cta8_pkg::OP_MOVW, cta8_pkg::AM_ABS, 16'h1235);
        check8("word addr", 8'h34, maddr[7:0]);
        bus(1'h0, cta8_pkg::RB_STATUS_LOW_BYTE, 8'h00);
        check8("flags", exp[7:0], got);
        bus(1'h0, cta8_pkg::RB_STAT, 8'h00);
        check8("odd", 8'h02, got);
        bus(1'h1, cta8_pkg::RB_STAT, 8'h02);
        bus(1'h0, cta8_pkg::RB_STAT, 8'h00);
        check8("odd clear", 8'h00, got);
        run(cta8_pkg::OP_MOV, cta8_pkg::AM_SADDR, 16'h0010);
        check8("short page", 8'hFF, maddr[15:8]);
        run(cta8_pkg::OP_LDSL, cta8_pkg::AM_IMM, 16'h00D5);
        bus(1'h0, cta8_pkg::RB_STATUS_LOW_BYTE, 8'h00);
        check8("status load", 8'hD5, got);
        // clock enable low must swallow a bus write
        bus(1'h1, 8'h0F, 8'h5A);
        ce <= 1'h0;
        bus(1'h1, 8'h0F, 8'hA5);
        ce <= 1'h1;
        bus(1'h0, 8'h0F, 8'h00);
        check8("frozen", 8'h5A, got);
        bus(1'h0, 8'h40, 8'h00);
        check8("unmapped", 8'h00, got);
        end_sim();
    end
    initial begin
        #40us n_fail++;
        end_sim();
    end
endmodule

// [testbench/cta8_sva.sv]
module cta8_sva (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 ce,
    input wire logic                 cmd_valid,
    input wire logic                 cmd_ready,
    input wire logic                 done,
    input wire cta8_pkg::cta8_opnd_s opnd,
    input wire cta8_pkg::cta8_dec_s  dec,
    input wire logic [7:0]           rb_addr,
    input wire logic                 rb_rd,
    input wire logic [7:0]           rb_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take; cmd_valid && cmd_ready; endsequence
    property p_done; s_take |-> ##[2:3] done; endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_pulse; done |=> !done; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_busy; s_take |=> !cmd_ready; endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
    property p_unmap; rb_rd && rb_addr > cta8_pkg::RB_STAT |=> rb_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
    property p_hold; !rb_rd |=> $stable(rb_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    // past guards: the edge after release or after a frozen edge still shows stale operands
    property p_rel; $past(rst_n) && $past(ce) |-> dec.rel_target ==
        $past(opnd.next_pc) + {{8{$past(opnd.disp[7])}}, $past(opnd.disp)}; endproperty
    a_rel: assert property (p_rel) else $error("bad relative target");
    property p_call; $past(rst_n) && $past(ce) |-> dec.call_target == {5'h01, $past(opnd.call11)}; endproperty
    a_call: assert property (p_call) else $error("bad call target");
    property p_code; $past(rst_n) && $past(ce) |-> dec.code_rp1 == {1'h1, $past(opnd.pair)}; endproperty
    a_code: assert property (p_code) else $error("bad pair code");
endmodule
bind cta8_core cta8_sva cta8_sva_inst (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .ce(ce), .done(done), .opnd(opnd), .dec(dec), .rb_addr(rb_addr), .rb_rd(rb_rd), .rb_rdata(rb_rdata));
